// ==== hdl/ppm_cfg.svh ====
// Offsets, field positions, reset values and sizes of the port pin mux.
// Included by the interface and the design modules; definitions only.
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

`define PPM_NPORT       10
`define PPM_NPIN        80
`define PPM_PORT_W      8
`define PPM_SYNC_STAGES 2

// Per-port block: byte address = port * 16 + offset
`define PPM_OFF_SEL     4'h0
`define PPM_OFF_OUT     4'h4
`define PPM_OFF_INSEL   4'h8
`define PPM_OFF_IN      4'hC
// Global block sits after the last port block
`define PPM_GLB_BLK     4'hA
`define PPM_OFF_EMI     4'h0
`define PPM_OFF_POL     4'h4

// Bus control register fields
`define PPM_EMI_MODE_LSB 0
`define PPM_EMI_BSEL_BIT 2
`define PPM_EMI_RST      3'h0

// Polarity register fields
`define PPM_POL_IRQ     0
`define PPM_POL_ALE     1
`define PPM_POL_CAP     2
`define PPM_POL_CMP     3
`define PPM_POL_TACH    4
`define PPM_POL_ESTOP   5
`define PPM_POL_PHASE   6
`define PPM_POL_W       7
`define PPM_POL_RST     7'h00

// Peripheral signal group widths
`define PPM_IRQ_W       8
`define PPM_CAP_W       8
`define PPM_CMP_W       8
`define PPM_PHASE_W     6

// First pin of each bus port
`define PPM_P7_LSB      56
`define PPM_P8_LSB      64
`define PPM_P9_LSB      72

`endif

// ==== hdl/ppm_pkg.sv ====
// Types of the port pin mux.
// Assumes ppm_cfg.svh for all numeric constants.
package ppm_pkg;
	typedef enum logic [1:0] {
		PPM_SEL_IN   = 2'b00,
		PPM_SEL_ALT1 = 2'b01,
		PPM_SEL_ALT2 = 2'b10,
		PPM_SEL_ALT3 = 2'b11
	} ppm_sel_t;

	typedef enum logic [1:0] {
		PPM_EMI_OFF   = 2'b00,
		PPM_EMI_NMUX8 = 2'b01,
		PPM_EMI_MUX16 = 2'b10,
		PPM_EMI_RSVD  = 2'b11
	} ppm_emi_mode_t;
endpackage

// ==== hdl/ppm_sync_if.sv ====
// Synchronised pin levels passed from the input stage to the mux.
// Assumes one clock domain on both sides.
`timescale 1ns/1ns
`include "ppm_cfg.svh"
interface ppm_sync_if;
	logic [`PPM_NPIN-1:0] level;
	modport src (output level);
	modport dst (input level);
endinterface

// ==== hdl/ppm_pin_sync.sv ====
// Two-stage synchroniser for every port pin input.
// Assumes pins are asynchronous to pclk.
`timescale 1ns/1ns
`include "ppm_cfg.svh"
module ppm_pin_sync (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [`PPM_NPIN-1:0] pin_in,
	ppm_sync_if.src                   sync
);
	logic [`PPM_NPIN-1:0] meta_q;
	logic [`PPM_NPIN-1:0] meta_d;
	logic [`PPM_NPIN-1:0] lvl_q;
	logic [`PPM_NPIN-1:0] lvl_d;

	always_comb begin
		meta_d = pin_in;
		lvl_d  = meta_q;
	end

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			lvl_q  <= '0;
		end else begin
			meta_q <= meta_d;
			lvl_q  <= lvl_d;
		end
	end

	assign sync.level = lvl_q;
endmodule // ppm_pin_sync

// ==== hdl/ppm_port_mux.sv ====
// Pin function mux for ports 0 to 9 with APB control registers.
// Assumes APB master on pclk; peripherals and bus engine on pclk.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "ppm_cfg.svh"
module ppm_port_mux (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [`PPM_NPIN-1:0]    pin_in,
	output logic [`PPM_NPIN-1:0]         pin_out,
	output logic [`PPM_NPIN-1:0]         pin_oe_n,
	input  wire logic [`PPM_NPIN-1:0]    alt2_out,
	input  wire logic [`PPM_NPIN-1:0]    alt3_out,
	output logic [`PPM_NPIN-1:0]         def_in,
	output logic [`PPM_NPIN-1:0]         alt1_in,
	input  wire logic [23:0]             emi_addr,
	input  wire logic [15:0]             emi_wdata,
	input  wire logic                    emi_data_oe,
	input  wire logic                    ext_bus_address_latch_raw,
	input  wire logic                    emi_wr_low_n,
	input  wire logic                    emi_wr_high_n,
	input  wire logic                    low_byte_select_n,
	input  wire logic                    upper_byte_select_n,
	output logic [15:0]                  emi_rdata,
	output logic                         ext_bus_address_latch,
	output logic                         low_byte_write_strobe_n,
	output logic                         high_byte_write_strobe_n,
	input  wire logic [`PPM_IRQ_W-1:0]   irq_raw,
	input  wire logic [`PPM_CAP_W-1:0]   cap_raw,
	input  wire logic [`PPM_CMP_W-1:0]   cmp_raw,
	input  wire logic                    tach_raw,
	input  wire logic                    estop_raw,
	input  wire logic [`PPM_PHASE_W-1:0] phase_raw,
	output logic [`PPM_IRQ_W-1:0]        irq_adj,
	output logic [`PPM_CAP_W-1:0]        cap_adj,
	output logic [`PPM_CMP_W-1:0]        cmp_adj,
	output logic                         tach_adj,
	output logic                         estop_adj,
	output logic [`PPM_PHASE_W-1:0]      phase_adj
);
	localparam int NP = `PPM_NPORT;
	localparam int PW = `PPM_PORT_W;

	ppm_sync_if sync_if ();

	ppm_pin_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (pin_in),
		.sync    (sync_if.src)
	);

	// Pin drive for one select code: {drive, value}
	function automatic logic [1:0] pin_drive(
		input logic [1:0] sel,
		input logic       gpio,
		input logic       alt2,
		input logic       alt3
	);
		logic [1:0] r;
		r = 2'b00;
		case (ppm_pkg::ppm_sel_t'(sel))
			ppm_pkg::PPM_SEL_IN:   r = 2'b00;
			ppm_pkg::PPM_SEL_ALT1: r = {1'b1, gpio};
			ppm_pkg::PPM_SEL_ALT2: r = {1'b1, alt2};
			ppm_pkg::PPM_SEL_ALT3: r = {1'b1, alt3};
			default:               r = 2'b00;
		endcase
		return r;
	endfunction

	// Register file
	logic [NP-1:0][2*PW-1:0]     sel_q, sel_d;
	logic [NP-1:0][PW-1:0]       out_q, out_d;
	logic [NP-1:0][PW-1:0]       insel_q, insel_d;
	logic [2:0]                  emi_q, emi_d;
	logic [`PPM_POL_W-1:0]       pol_q, pol_d;
	logic [31:0]                 prdata_q, prdata_d;
	logic [3:0]                  blk;
	logic [3:0]                  off;
	logic                        setup;
	logic                        access;
	logic                        blk_ok;
	ppm_pkg::ppm_emi_mode_t      mode;
	logic [`PPM_NPIN-1:0]        lvl;

	assign blk    = paddr[7:4];
	assign off    = {paddr[3:2], 2'b00};
	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign blk_ok = (blk < 4'(NP)) || (blk == `PPM_GLB_BLK && off[3] == 1'b0);
	assign mode   = ppm_pkg::ppm_emi_mode_t'(emi_q[`PPM_EMI_MODE_LSB +: 2]);
	assign lvl    = sync_if.level;
	// Zero wait states; errors on any unmapped word
	assign pready  = 1'b1;
	assign pslverr = access && !blk_ok;
	assign prdata  = prdata_q;

	always_comb begin
		sel_d    = sel_q;
		out_d    = out_q;
		insel_d  = insel_q;
		emi_d    = emi_q;
		pol_d    = pol_q;
		prdata_d = prdata_q;
		if (access && pwrite && blk_ok) begin
			if (blk == `PPM_GLB_BLK) begin
				if (off == `PPM_OFF_EMI)
					emi_d = pwdata[2:0];
				else
					pol_d = pwdata[`PPM_POL_W-1:0];
			end else begin
				case (off)
					`PPM_OFF_SEL:   sel_d[blk] = pwdata[2*PW-1:0];
					`PPM_OFF_OUT:   out_d[blk] = pwdata[PW-1:0];
					`PPM_OFF_INSEL: insel_d[blk] = pwdata[PW-1:0];
					// Pin level word is read-only; writes drop silently
					default:        ;
				endcase
			end
		end
		// Read data is latched in the setup cycle so it is stable in access
		if (setup && !pwrite) begin
			prdata_d = 32'h0000_0000;
			if (blk == `PPM_GLB_BLK) begin
				if (off == `PPM_OFF_EMI)
					prdata_d = {29'h0, emi_q};
				else if (off == `PPM_OFF_POL)
					prdata_d = {25'h0, pol_q};
			end else if (blk < 4'(NP)) begin
				case (off)
					`PPM_OFF_SEL:   prdata_d = {16'h0, sel_q[blk]};
					`PPM_OFF_OUT:   prdata_d = {24'h0, out_q[blk]};
					`PPM_OFF_INSEL: prdata_d = {24'h0, insel_q[blk]};
					`PPM_OFF_IN:    prdata_d = {24'h0, lvl[blk*PW +: PW]};
					default:        prdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q    <= '0;
			out_q    <= '0;
			insel_q  <= '0;
			emi_q    <= `PPM_EMI_RST;
			pol_q    <= `PPM_POL_RST;
			prdata_q <= 32'h0000_0000;
		end else begin
			sel_q    <= sel_d;
			out_q    <= out_d;
			insel_q  <= insel_d;
			emi_q    <= emi_d;
			pol_q    <= pol_d;
			prdata_q <= prdata_d;
		end
	end

	// Pin and peripheral outputs
	logic [`PPM_NPIN-1:0]        pout_d, poe_n_d, def_d, alt1_d;
	logic [`PPM_NPIN-1:0]        pout_q, poe_n_q, def_q, alt1_q;
	logic [15:0]                 rdata_d, rdata_q;
	logic [2:0]                  emi_pins_d, emi_pins_q;
	logic [`PPM_IRQ_W-1:0]       irq_d, irq_q;
	logic [`PPM_CAP_W-1:0]       cap_d, cap_q;
	logic [`PPM_CMP_W-1:0]       cmp_d, cmp_q;
	logic [1:0]                  mot_d, mot_q;
	logic [`PPM_PHASE_W-1:0]     ph_d, ph_q;
	logic [1:0]                  drv;
	logic                        ale_drv;

	always_comb begin
		drv = 2'b00;
		for (int p = 0; p < `PPM_NPIN; p++) begin
			drv = pin_drive(sel_q[p/PW][2*(p%PW) +: 2], out_q[p/PW][p%PW],
				alt2_out[p], alt3_out[p]);
			pout_d[p]  = drv[0];
			poe_n_d[p] = !drv[1];
		end
		// Bus modes take ports 7 to 9 over from the pin selects
		ale_drv = ext_bus_address_latch_raw || emi_data_oe;
		case (mode)
			ppm_pkg::PPM_EMI_NMUX8: begin
				pout_d[`PPM_P8_LSB +: 8]  = emi_wdata[7:0];
				poe_n_d[`PPM_P8_LSB +: 8] = {8{!emi_data_oe}};
				pout_d[`PPM_P9_LSB +: 8]  = emi_addr[7:0];
				poe_n_d[`PPM_P9_LSB +: 8] = 8'h00;
				pout_d[`PPM_P7_LSB +: 8]  = emi_addr[15:8];
				poe_n_d[`PPM_P7_LSB +: 8] = 8'h00;
			end
			ppm_pkg::PPM_EMI_MUX16: begin
				pout_d[`PPM_P8_LSB +: 16] = ext_bus_address_latch_raw ? emi_addr[15:0]
					: emi_wdata;
				poe_n_d[`PPM_P8_LSB +: 16] = {16{!ale_drv}};
				pout_d[`PPM_P7_LSB +: 8]  = emi_addr[23:16];
				poe_n_d[`PPM_P7_LSB +: 8] = 8'h00;
			end
			default: begin
			end
		endcase
		// Pin levels always feed the inputs, whatever drives the pin
		def_d  = lvl & ~insel_q;
		alt1_d = lvl & insel_q;
		rdata_d = lvl[`PPM_P8_LSB +: 16];
		emi_pins_d[0] = ext_bus_address_latch_raw ^ pol_q[`PPM_POL_ALE];
		// Byte select reuses the strobe pins; one mode at a time
		emi_pins_d[1] = emi_q[`PPM_EMI_BSEL_BIT] ? low_byte_select_n
			: emi_wr_low_n;
		emi_pins_d[2] = emi_q[`PPM_EMI_BSEL_BIT] ? upper_byte_select_n
			: emi_wr_high_n;
		irq_d = irq_raw ^ {`PPM_IRQ_W{pol_q[`PPM_POL_IRQ]}};
		cap_d = cap_raw ^ {`PPM_CAP_W{pol_q[`PPM_POL_CAP]}};
		cmp_d = cmp_raw ^ {`PPM_CMP_W{pol_q[`PPM_POL_CMP]}};
		mot_d = {estop_raw ^ pol_q[`PPM_POL_ESTOP],
			tach_raw ^ pol_q[`PPM_POL_TACH]};
		ph_d  = phase_raw ^ {`PPM_PHASE_W{pol_q[`PPM_POL_PHASE]}};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pout_q     <= '0;
			poe_n_q    <= '1;
			def_q      <= '0;
			alt1_q     <= '0;
			rdata_q    <= 16'h0000;
			emi_pins_q <= 3'h6;
			irq_q      <= '0;
			cap_q      <= '0;
			cmp_q      <= '0;
			mot_q      <= 2'h0;
			ph_q       <= '0;
		end else begin
			pout_q     <= pout_d;
			poe_n_q    <= poe_n_d;
			def_q      <= def_d;
			alt1_q     <= alt1_d;
			rdata_q    <= rdata_d;
			emi_pins_q <= emi_pins_d;
			irq_q      <= irq_d;
			cap_q      <= cap_d;
			cmp_q      <= cmp_d;
			mot_q      <= mot_d;
			ph_q       <= ph_d;
		end
	end

	assign pin_out                  = pout_q;
	assign pin_oe_n                 = poe_n_q;
	assign def_in                   = def_q;
	assign alt1_in                  = alt1_q;
	assign emi_rdata                = rdata_q;
	assign ext_bus_address_latch    = emi_pins_q[0];
	assign low_byte_write_strobe_n  = emi_pins_q[1];
	assign high_byte_write_strobe_n = emi_pins_q[2];
	assign irq_adj                  = irq_q;
	assign cap_adj                  = cap_q;
	assign cmp_adj                  = cmp_q;
	assign tach_adj                 = mot_q[0];
	assign estop_adj                = mot_q[1];
	assign phase_adj                = ph_q;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [7:0] exp_in;
	assign exp_in = 8'(lvl >> {paddr[7:4], 3'b000});

	a_idle_hiz: assert property (
		(sel_q == '0 && mode == ppm_pkg::PPM_EMI_OFF) |=> &pin_oe_n)
		else $error("Idle pins are driven");
	a_gpio_read: assert property (
		(setup && !pwrite && blk < 4'(NP) && off == `PPM_OFF_IN)
		|=> prdata == {24'h0, $past(exp_in)})
		else $error("Pin read data mismatch");
	// Each pin level reaches exactly one of the two input paths
	a_def_route: assert property (
		1'b1 |=> ((def_in | alt1_in) == $past(lvl)
		&& (def_in & $past(insel_q)) == '0))
		else $error("Default input routing wrong");
	a_alt2_pin1: assert property (
		(sel_q[0][3:2] == 2'b10) |=> (!pin_oe_n[1]
		&& pin_out[1] == $past(alt2_out[1])))
		else $error("Alternate output not on pin");
	a_nmux_data: assert property (
		(mode == ppm_pkg::PPM_EMI_NMUX8 && emi_data_oe)
		|=> (pin_out[71:64] == $past(emi_wdata[7:0])
		&& pin_out[79:72] == $past(emi_addr[7:0])
		&& pin_oe_n[79:56] == 24'h000000))
		else $error("Non-muxed bus pins wrong");
	a_mux_addr: assert property (
		(mode == ppm_pkg::PPM_EMI_MUX16 && ext_bus_address_latch_raw)
		|=> (pin_out[79:64] == $past(emi_addr[15:0])
		&& pin_out[63:56] == $past(emi_addr[23:16])))
		else $error("Muxed address phase wrong");
	a_ale_pol: assert property (
		1'b1 |=> ext_bus_address_latch
		== $past(ext_bus_address_latch_raw ^ pol_q[`PPM_POL_ALE]))
		else $error("Address latch polarity wrong");
	a_byte_sel: assert property (
		emi_q[`PPM_EMI_BSEL_BIT] ##1 emi_q[`PPM_EMI_BSEL_BIT]
		|-> low_byte_write_strobe_n == $past(low_byte_select_n))
		else $error("Byte select not on strobe pin");
	a_cmp_pol: assert property (
		$rose(pol_q[`PPM_POL_CMP]) && $stable(cmp_raw)
		|=> cmp_adj == ~$past(cmp_adj))
		else $error("Compare polarity not applied");
endmodule // ppm_port_mux

// ==== test/ppm_pin_model.sv ====
// Board-side model of the 80 port pins and their external circuits.
// Assumes the mux reports drive value and active-low enable per pin.
`timescale 1ns/1ns
module ppm_pin_model (
	pin_out,
	pin_oe_n,
	ext_val,
	pin_in
);
	input  wire logic [79:0] pin_out;
	input  wire logic [79:0] pin_oe_n;
	input  wire logic [79:0] ext_val;
	output logic      [79:0] pin_in;

	// Board drives every pin the mux leaves undriven
	always_comb begin
		for (int i = 0; i < 80; i++) begin
			pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_val[i];
		end
	end
endmodule // ppm_pin_model

// ==== test/test_port_pin_function_mux.sv ====
// Self-checking bench for the port pin mux, one task per scenario.
// Assumes a zero-wait APB slave and the board model on the pins.
`timescale 1ns/1ns
module test_port_pin_function_mux;
	localparam logic [79:0] XV = 80'h0123_4567_89AB_CDEF_5A3C;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr, irq_raw, cap_raw, cmp_raw, irq_adj, cap_adj, cmp_adj;
	logic [31:0] pwdata, prdata, rd;
	logic [79:0] pin_in, pin_out, pin_oe_n, alt2_out, alt3_out, def_in;
	logic [79:0] alt1_in;
	logic [23:0] emi_addr;
	logic [15:0] emi_wdata, emi_rdata;
	logic        emi_data_oe, ext_bus_address_latch_raw, emi_wr_low_n, emi_wr_high_n;
	logic        low_byte_select_n, upper_byte_select_n, ext_bus_address_latch;
	logic        low_byte_write_strobe_n, high_byte_write_strobe_n;
	logic        tach_raw, estop_raw, tach_adj, estop_adj;
	logic [5:0]  phase_raw, phase_adj;
	int          fail_count, n_checks;

	ppm_port_mux i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n,
		.alt2_out, .alt3_out, .def_in, .alt1_in, .emi_addr, .emi_wdata,
		.emi_data_oe, .ext_bus_address_latch_raw, .emi_wr_low_n, .emi_wr_high_n,
		.low_byte_select_n, .upper_byte_select_n, .emi_rdata,
		.ext_bus_address_latch, .low_byte_write_strobe_n,
		.high_byte_write_strobe_n, .irq_raw, .cap_raw, .cmp_raw, .tach_raw,
		.estop_raw, .phase_raw, .irq_adj, .cap_adj, .cmp_adj, .tach_adj,
		.estop_adj, .phase_adj);
	ppm_pin_model i_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_val(XV), .pin_in(pin_in));

	always #4 pclk = ~pclk;

	task chk(input string nm, input logic [79:0] got, input logic [79:0] x);
		n_checks++;
		if (got !== x) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, x, got);
		end
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Holds the request until pready is seen high at a rising edge;
	// only the watchdog ends a wait that never completes
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic er);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, e);
	endtask

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, rd, e);
		chk(nm, rd, x);
	endtask

	// Covers register output plus the two-stage pin synchroniser
	task settle;
		repeat (6) @(posedge pclk);
	endtask

	task t_reset;
		settle;
		chk("oe_n", pin_oe_n, {80{1'b1}});
		chk("out", pin_out, 80'h0);
		chk("def_in", def_in, XV);
		chk("alt1_in", alt1_in, 80'h0);
		chk("strobes", {low_byte_write_strobe_n, high_byte_write_strobe_n},
			2'b11);
		rdc("sel0", 8'h00, 32'h0);
		rdc("buscfg", 8'hA0, 32'h0);
	endtask

	task t_gpio;
		for (int p = 0; p < 10; p++) begin
			rdc("in", 8'(p * 16 + 12), {24'h0, XV[p*8 +: 8]});
		end
	endtask

	task t_sel;
		wr(8'h04, 32'h06);
		wr(8'h00, 32'h39);
		settle;
		chk("gpio_low", pin_out[2:0], 3'b000);
		chk("sel_oe", pin_oe_n[7:0], 8'hF8);
		alt2_out <= {80{1'b1}};
		alt3_out <= {80{1'b1}};
		settle;
		chk("alt_out", pin_out[2:0], 3'b110);
		rdc("in_alt", 8'h0C, {24'h0, XV[7:3], 3'b110});
		wr(8'h00, 32'h0);
	endtask

	task t_insel;
		wr(8'h18, 32'h0F);
		settle;
		chk("alt1", alt1_in[15:8], XV[15:8] & 8'h0F);
		chk("def1", def_in[15:8], XV[15:8] & 8'hF0);
		chk("def0", def_in[7:0], XV[7:0]);
		rdc("in1", 8'h1C, {24'h0, XV[15:8]});
		wr(8'h18, 32'h0);
	endtask

	task t_emi;
		emi_addr <= 24'h3C96E1;
		emi_wdata <= 16'hB47D;
		emi_data_oe <= 1'b1;
		wr(8'hA0, 32'(ppm_pkg::PPM_EMI_NMUX8));
		settle;
		chk("m1_pins", pin_out[79:56], 24'hE17D96);
		chk("m1_oe", pin_oe_n[79:56], 24'h0);
		emi_data_oe <= 1'b0;
		settle;
		chk("m1_doff", pin_oe_n[71:64], 8'hFF);
		chk("m1_rdata", emi_rdata, 16'hE123);
		wr(8'hA0, 32'(ppm_pkg::PPM_EMI_MUX16));
		ext_bus_address_latch_raw <= 1'b1;
		settle;
		chk("m2_addr", pin_out[79:56], 24'h96E13C);
		chk("m2_oe", pin_oe_n[79:56], 24'h0);
		ext_bus_address_latch_raw <= 1'b0;
		emi_data_oe <= 1'b1;
		settle;
		chk("m2_data", pin_out[79:64], 16'hB47D);
		emi_wr_low_n <= 1'b0;
		upper_byte_select_n <= 1'b0;
		settle;
		chk("strobe", {low_byte_write_strobe_n, high_byte_write_strobe_n},
			2'b01);
		wr(8'hA0, 32'h4);
		settle;
		chk("bytesel", {low_byte_write_strobe_n, high_byte_write_strobe_n},
			2'b10);
		// Spare mode code must leave the bus ports to their selects
		wr(8'hA0, 32'h3);
		settle;
		chk("rsvd_oe", pin_oe_n[79:56], {24{1'b1}});
		wr(8'hA0, 32'h0);
		settle;
		chk("off_oe", pin_oe_n[79:56], {24{1'b1}});
	endtask

	// One polarity bit at a time, so a swapped bit is seen
	task t_pol;
		logic [6:0] p;
		ext_bus_address_latch_raw <= 1'b1;
		for (int b = -1; b < 7; b++) begin
			p = (b < 0) ? 7'h00 : 7'(1 << b);
			wr(8'hA4, {25'h0, p});
			settle;
			chk("adj", {irq_adj, cap_adj, cmp_adj, tach_adj, estop_adj,
				phase_adj}, {irq_raw ^ {8{p[0]}}, cap_raw ^ {8{p[2]}},
				cmp_raw ^ {8{p[3]}}, tach_raw ^ p[4], estop_raw ^ p[5],
				phase_raw ^ {6{p[6]}}});
			chk("ale", ext_bus_address_latch, 1'b1 ^ p[1]);
		end
		rdc("pol", 8'hA4, 32'h40);
	endtask

	task t_unmapped;
		apb(1'b0, 8'hB0, 32'h0, rd, e);
		chk("rd_err", e, 1'b1);
		chk("rd_zero", rd, 32'h0);
		apb(1'b1, 8'hA8, 32'hFFFF_FFFF, rd, e);
		chk("wr_err", e, 1'b1);
		wr(8'h0C, 32'hFF);
		chk("ro_err", e, 1'b0);
		rdc("ro_in", 8'h0C, {24'h0, XV[7:0]});
	endtask

	// Reset in mid-run must drop every configured drive and routing
	task t_rerst;
		wr(8'h00, 32'h5555);
		wr(8'h18, 32'hFF);
		settle;
		chk("cfg_oe", pin_oe_n[7:0], 8'h00);
		presetn <= 1'b0;
		@(posedge pclk);
		chk("rst_oe", pin_oe_n, {80{1'b1}});
		presetn <= 1'b1;
		settle;
		chk("rel_oe", pin_oe_n, {80{1'b1}});
		chk("rel_def", def_in, XV);
		chk("rel_alt1", alt1_in, 80'h0);
		rdc("rel_sel", 8'h00, 32'h0);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{alt2_out, alt3_out, emi_addr, emi_wdata} = '0;
		{emi_data_oe, ext_bus_address_latch_raw} = 2'b00;
		{emi_wr_low_n, emi_wr_high_n} = 2'b11;
		{low_byte_select_n, upper_byte_select_n} = 2'b11;
		{irq_raw, cap_raw, cmp_raw} = 24'h5AC396;
		{tach_raw, estop_raw, phase_raw} = 8'hAD;
		fail_count = 0;
		n_checks = 0;
		repeat (2) @(posedge pclk);
		chk("oe_rst", pin_oe_n, {80{1'b1}});
		@(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_gpio;
		t_sel;
		t_insel;
		t_emi;
		t_pol;
		t_unmapped;
		t_rerst;
		tally_and_finish;
	end

	// Whole run takes well under 2000 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		tally_and_finish;
	end
endmodule // test_port_pin_function_mux
